// file: rtl/cmp_ctrl.sv
// digital control around two comparators: registers, gate sources, flags, irq
// assumes a single-cycle register port and an analog core that obeys the
// per-comparator analog controls it is given
//
// How it works
// - each comparator's gate output goes through a latch when sync_enable set.
// - the latch captures the output on the falling counter clock edge.
// - with a counter prescaler the latch uses the prescaled clock input.
// - each comparator output is offered as a counter gate source.
// - each comparator has its own rising and falling edge detectors.
// - enabled edge sets that comparator's interrupt flag.
// - interrupt needs on, speed, enable, edge enable, peripheral and global.
// - flag cleared only by software; a same-cycle edge leaves it set.
// - invert or on/off toggles may trigger edge detectors while disabled.
// - plus_input_select picks plus pin, DAC, fixed reference or ground.
// - cmp_on low disconnects every input of that comparator.
// - minus_input_select picks one of four pins for the inverting input.
// - control0 bits: on, output, pin enable, invert, zero, speed, hyst, sync.
// - control1 bits: rise en, fall en, plus select, zeros, minus select.
// - comparator 2 flag/enable in bit 6, comparator 1 in bit 5.
// - global enable at bit 7, peripheral enable at bit 6.
// - unimplemented bits read as zero.
`timescale 1ns/1ps
`include "cmp_ctrl_params.svh"
module cmp_ctrl #(
    parameter int NUM_CMP = 2
) (
    // clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        reset,
    // register port
    input  wire logic [3:0]                  reg_addr,
    input  wire logic [7:0]                  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [7:0]                  reg_rdata,
    // analog core
    input  wire logic [NUM_CMP-1:0]          raw_cmp_in,
    output cmp_ctrl_pkg::analog_ctrl_t       analog_ctrl [NUM_CMP],
    // companion counter
    input  wire logic                        cnt_clk_in,
    output logic      [NUM_CMP-1:0]          gate_src,
    // pins
    output logic      [NUM_CMP-1:0]          cmp_pin_out,
    output logic      [NUM_CMP-1:0]          cmp_pin_oe,
    // interrupt
    output logic                             int_request,
    output logic                             cmp_wake
);

    cmp_ctrl_pkg::control0_t ctrl0_r [NUM_CMP];
    cmp_ctrl_pkg::control1_t ctrl1_r [NUM_CMP];
    logic [7:0]         int_ctrl_r;
    logic [7:0]         periph_enable2_reg_r;
    logic [7:0]         periph_flag2_reg_r;
    logic [NUM_CMP-1:0] out_value;
    logic [NUM_CMP-1:0] rise_evt;
    logic [NUM_CMP-1:0] fall_evt;
    logic [NUM_CMP-1:0] flag_set;
    logic [NUM_CMP-1:0] cmp_int;
    logic [7:0]         flag_set_vec;
    logic [7:0]         mirror;
    logic [7:0]         rdata_nxt;
    logic [7:0]         periph_enable2_reg_wmask;

    localparam int FLAG_POS [2] = '{`CMP1_FLAG_BIT, `CMP2_FLAG_BIT};

    // ------------------------------------------------------------
    // per-comparator logic
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_CMP; g++) begin : ch
            localparam logic [3:0] OFS0 = 4'(2 * g);
            localparam logic [3:0] OFS1 = 4'(2 * g + 1);

            cmp_channel u_chan (
                .sys_clk     (sys_clk),
                .reset       (reset),
                .raw_in      (raw_cmp_in[g]),
                .cnt_clk_in  (cnt_clk_in),
                .cmp_on      (ctrl0_r[g].cmp_on),
                .out_invert  (ctrl0_r[g].out_invert),
                .sync_enable (ctrl0_r[g].sync_enable),
                .out_value   (out_value[g]),
                .gate_out    (gate_src[g]),
                .rise_evt    (rise_evt[g]),
                .fall_evt    (fall_evt[g])
            );

            // status bit of control0 is read-only; hardware drives it
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    ctrl0_r[g] <= `REG_RESET;
                end else if (reg_wr && reg_addr == OFS0) begin
                    ctrl0_r[g] <= (reg_wdata & `C0_WMASK) | (8'(out_value[g]) << `C0_OUT_BIT);
                end else begin
                    ctrl0_r[g].cmp_output <= out_value[g];
                end
            end

            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    ctrl1_r[g] <= `REG_RESET;
                end else if (reg_wr && reg_addr == OFS1) begin
                    ctrl1_r[g] <= reg_wdata & `C1_WMASK;
                end
            end

            assign flag_set[g] = (rise_evt[g] & ctrl1_r[g].rise_int_enable)
                               | (fall_evt[g] & ctrl1_r[g].fall_int_enable);

            assign cmp_int[g] = periph_flag2_reg_r[FLAG_POS[g]] & periph_enable2_reg_r[FLAG_POS[g]]
                              & ctrl0_r[g].cmp_on & ctrl0_r[g].speed_select
                              & (ctrl1_r[g].rise_int_enable | ctrl1_r[g].fall_int_enable);

            // analog side: inputs all dropped while off
            always_comb begin
                analog_ctrl[g].cmp_on = ctrl0_r[g].cmp_on;
                analog_ctrl[g].speed_select = ctrl0_r[g].speed_select;
                analog_ctrl[g].hysteresis_enable = ctrl0_r[g].hysteresis_enable;
                analog_ctrl[g].plus_input_select = ctrl1_r[g].plus_input_select;
                analog_ctrl[g].minus_input_select = ctrl1_r[g].minus_input_select;
                analog_ctrl[g].plus_onehot = 4'h0;
                analog_ctrl[g].minus_onehot = 4'h0;
                if (ctrl0_r[g].cmp_on) begin
                    analog_ctrl[g].plus_onehot[ctrl1_r[g].plus_input_select] = 1'b1;
                    analog_ctrl[g].minus_onehot[ctrl1_r[g].minus_input_select] = 1'b1;
                end
            end

            assign cmp_pin_out[g] = ctrl0_r[g].cmp_output;
            assign cmp_pin_oe[g] = ctrl0_r[g].pin_output_enable;
        end
    endgenerate

    // ------------------------------------------------------------
    // flag and enable registers
    // ------------------------------------------------------------
    always_comb begin
        flag_set_vec = 8'h00;
        mirror = 8'h00;
        for (int i = 0; i < NUM_CMP; i++) begin
            flag_set_vec[FLAG_POS[i]] = flag_set[i];
            mirror[i] = out_value[i];
        end
    end

    // only comparator flags live here; other peripheral bits read zero
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            periph_flag2_reg_r <= `REG_RESET;
        end else if (reg_wr && reg_addr == `OFS_PERIPH_FLAG2) begin
            // set wins over the clearing write
            periph_flag2_reg_r <= ((reg_wdata | flag_set_vec) & periph_enable2_reg_wmask) | flag_set_vec;
        end else begin
            periph_flag2_reg_r <= periph_flag2_reg_r | flag_set_vec;
        end
    end

    always_comb begin
        periph_enable2_reg_wmask = 8'h00;
        for (int i = 0; i < NUM_CMP; i++) begin
            periph_enable2_reg_wmask[FLAG_POS[i]] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            periph_enable2_reg_r <= `REG_RESET;
        end else if (reg_wr && reg_addr == `OFS_PERIPH_EN2) begin
            periph_enable2_reg_r <= reg_wdata & periph_enable2_reg_wmask;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            int_ctrl_r <= `REG_RESET;
        end else if (reg_wr && reg_addr == `OFS_INT_CTRL) begin
            // only the two enables are held here
            int_ctrl_r <= reg_wdata & 8'hc0;
        end
    end

    // wake ignores the global enable, as sleep wake-up does
    assign cmp_wake = |cmp_int;
    assign int_request = cmp_wake & int_ctrl_r[`PERIPHERAL_INT_ENABLE_BIT] & int_ctrl_r[`GIE_BIT];

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_comb begin
        rdata_nxt = 8'h00;
        unique case (reg_addr)
            `OFS_CMP1_CTRL0:   rdata_nxt = ctrl0_r[0];
            `OFS_CMP1_CTRL1:   rdata_nxt = ctrl1_r[0];
            `OFS_CMP2_CTRL0:   rdata_nxt = (NUM_CMP > 1) ? ctrl0_r[NUM_CMP-1] : 8'h00;
            `OFS_CMP2_CTRL1:   rdata_nxt = (NUM_CMP > 1) ? ctrl1_r[NUM_CMP-1] : 8'h00;
            `OFS_CMP_MIRROR:   rdata_nxt = mirror;
            `OFS_INT_CTRL:     rdata_nxt = int_ctrl_r;
            `OFS_PERIPH_EN2:   rdata_nxt = periph_enable2_reg_r;
            `OFS_PERIPH_FLAG2: rdata_nxt = periph_flag2_reg_r;
            default:           rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

// file: rtl/cmp_ctrl_params.svh
// constants for the comparator control block: register offsets, bit positions
// assumes inclusion by bare name from the design and assertion files
`ifndef CMP_CTRL_PARAMS_SVH
`define CMP_CTRL_PARAMS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define OFS_CMP1_CTRL0    4'h0
`define OFS_CMP1_CTRL1    4'h1
`define OFS_CMP2_CTRL0    4'h2
`define OFS_CMP2_CTRL1    4'h3
`define OFS_CMP_MIRROR    4'h4
`define OFS_INT_CTRL      4'h5
`define OFS_PERIPH_EN2    4'h6
`define OFS_PERIPH_FLAG2  4'h7

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define C0_ON_BIT         7
`define C0_OUT_BIT        6
`define C0_OE_BIT         5
`define C0_INV_BIT        4
`define C0_SPEED_BIT      2
`define C0_HYS_BIT        1
`define C0_SYNC_BIT       0
`define C0_WMASK          8'hb7
`define C1_RISE_BIT       7
`define C1_FALL_BIT       6
`define C1_WMASK          8'hf3
`define CMP2_FLAG_BIT     6
`define CMP1_FLAG_BIT     5
`define GIE_BIT           7
`define PERIPHERAL_INT_ENABLE_BIT          6
`define PERIPH_ENABLE2_REG_WMASK        8'hf9
`define INT_CTRL_WMASK    8'hff

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define REG_RESET         8'h00

`endif

// file: rtl/cmp_ctrl_pkg.sv
// types shared by the comparator control block
// assumes nothing beyond the constants header
package cmp_ctrl_pkg;

    typedef enum logic [1:0] {
        PLUS_PIN,
        PLUS_DAC,
        PLUS_FIXED_REFERENCE,
        PLUS_GROUND
    } plus_sel_t;

    typedef struct packed {
        logic       cmp_on;
        logic       cmp_output;
        logic       pin_output_enable;
        logic       out_invert;
        logic       unused3;
        logic       speed_select;
        logic       hysteresis_enable;
        logic       sync_enable;
    } control0_t;

    typedef struct packed {
        logic       rise_int_enable;
        logic       fall_int_enable;
        plus_sel_t  plus_input_select;
        logic [1:0] unused;
        logic [1:0] minus_input_select;
    } control1_t;

    typedef struct packed {
        logic       cmp_on;
        logic       speed_select;
        logic       hysteresis_enable;
        plus_sel_t  plus_input_select;
        logic [1:0] minus_input_select;
        logic [3:0] plus_onehot;
        logic [3:0] minus_onehot;
    } analog_ctrl_t;

endpackage

// file: rtl/cmp_channel.sv
// one comparator channel: input capture, polarity, sync latch, edge detect
// assumes raw_in comes from the analog core, async to sys_clk; the counter
// clock arrives as a pin-level signal, prescaled when the counter prescales
`timescale 1ns/1ps
module cmp_channel (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    // analog core and counter clock
    input  wire logic raw_in,
    input  wire logic cnt_clk_in,
    // control
    input  wire logic cmp_on,
    input  wire logic out_invert,
    input  wire logic sync_enable,
    // results
    output logic      out_value,
    output logic      gate_out,
    output logic      rise_evt,
    output logic      fall_evt
);

    logic raw_s1_r;
    logic raw_s2_r;
    logic clk_s1_r;
    logic clk_s2_r;
    logic clk_prev_r;
    logic latch_r;
    logic prev_r;
    logic adj_nxt;

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            raw_s1_r <= 1'b0;
            raw_s2_r <= 1'b0;
            clk_s1_r <= 1'b0;
            clk_s2_r <= 1'b0;
            clk_prev_r <= 1'b0;
        end else begin
            raw_s1_r <= raw_in;
            raw_s2_r <= raw_s1_r;
            clk_s1_r <= cnt_clk_in;
            clk_s2_r <= clk_s1_r;
            clk_prev_r <= clk_s2_r;
        end
    end

    // off comparator reads low; invert still applies so toggles show as edges
    assign adj_nxt = (cmp_on & raw_s2_r) ^ out_invert;

    // ------------------------------------------------------------
    // counter gate latch
    // ------------------------------------------------------------
    // latch on falling counter clock so the gate is steady at its rising edge
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            latch_r <= 1'b0;
        end else if (clk_prev_r & ~clk_s2_r) begin
            latch_r <= adj_nxt;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            out_value <= 1'b0;
            gate_out <= 1'b0;
        end else begin
            out_value <= adj_nxt;
            gate_out <= sync_enable ? latch_r : adj_nxt;
        end
    end

    // ------------------------------------------------------------
    // edge detectors
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= out_value;
        end
    end

    assign rise_evt = out_value & ~prev_r;
    assign fall_evt = ~out_value & prev_r;

endmodule

// file: tb/cmp_ctrl_assertions.sv
// concurrent checks on the comparator control block ports
// assumes the register offsets and bit positions of the shared header
`timescale 1ns/1ps
`include "cmp_ctrl_params.svh"
module cmp_ctrl_assertions #(
    parameter int NUM_CMP = 2
) (
    // clock, reset, register port
    input wire logic                        sys_clk,
    input wire logic                        reset,
    input wire logic [3:0]                  reg_addr,
    input wire logic [7:0]                  reg_wdata,
    input wire logic                        reg_wr,
    input wire logic                        reg_rd,
    input wire logic [7:0]                  reg_rdata,
    // block outputs and counter clock
    input wire cmp_ctrl_pkg::analog_ctrl_t  analog_ctrl [NUM_CMP],
    input wire logic                        cnt_clk_in,
    input wire logic [NUM_CMP-1:0]          gate_src,
    input wire logic [NUM_CMP-1:0]          cmp_pin_oe,
    input wire logic                        int_request,
    input wire logic                        cmp_wake
);
    logic       sync0_r;
    logic       clk_d_r;
    logic [3:0] since_fall_r;

    // ---
    // helper: comparator 1 sync setting, cycles since counter clock fell
    // ---
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sync0_r      <= 1'b0;
            clk_d_r      <= 1'b1;
            since_fall_r <= 4'hf;
        end else begin
            if (reg_wr && reg_addr == `OFS_CMP1_CTRL0) begin
                sync0_r <= reg_wdata[`C0_SYNC_BIT];
            end
            clk_d_r <= cnt_clk_in;
            if (clk_d_r && !cnt_clk_in) begin
                since_fall_r <= 4'h0;
            end else if (since_fall_r != 4'hf) begin
                since_fall_r <= since_fall_r + 4'h1;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_off_isolated: assert property (
        (analog_ctrl[0].cmp_on || (analog_ctrl[0].plus_onehot | analog_ctrl[0].minus_onehot) == 4'h0)
        && (analog_ctrl[1].cmp_on || (analog_ctrl[1].plus_onehot | analog_ctrl[1].minus_onehot) == 4'h0))
        else $error("inputs connected while comparator off");
    a_plus_route: assert property (
        analog_ctrl[0].cmp_on |-> analog_ctrl[0].plus_onehot == 4'h1 << analog_ctrl[0].plus_input_select)
        else $error("plus input routing wrong");
    a_minus_route: assert property (
        analog_ctrl[1].cmp_on |-> analog_ctrl[1].minus_onehot == 4'h1 << analog_ctrl[1].minus_input_select)
        else $error("minus input routing wrong");
    a_irq_gated: assert property (
        int_request |-> cmp_wake && ((analog_ctrl[0].cmp_on && analog_ctrl[0].speed_select)
        || (analog_ctrl[1].cmp_on && analog_ctrl[1].speed_select)))
        else $error("interrupt without enabled comparator");
    a_oe_follows: assert property (
        reg_wr && reg_addr == `OFS_CMP2_CTRL0 |=> cmp_pin_oe[1] == $past(reg_wdata[`C0_OE_BIT]))
        else $error("pin enable not taken from control0");
    a_on_follows: assert property (
        reg_wr && reg_addr == `OFS_CMP1_CTRL0 ##1 1'b1 |-> analog_ctrl[0].cmp_on == $past(reg_wdata[7]))
        else $error("on bit not taken from control0");
    a_mirror_zero: assert property (
        reg_rd && reg_addr == `OFS_CMP_MIRROR |=> reg_rdata[7:2] == 6'h00)
        else $error("mirror upper bits not zero");
    a_ctrl1_gap: assert property (
        reg_rd && (reg_addr == `OFS_CMP1_CTRL1 || reg_addr == `OFS_CMP2_CTRL1)
        |=> reg_rdata[3:2] == 2'h0)
        else $error("control1 gap bits not zero");
    a_sync_gate: assert property (
        sync0_r && $past(sync0_r, 8) && $changed(gate_src[0]) |-> since_fall_r <= 4'h8)
        else $error("synced gate moved without counter clock fall");
endmodule

bind cmp_ctrl cmp_ctrl_assertions #(.NUM_CMP(NUM_CMP)) u_cmp_ctrl_assertions (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .analog_ctrl(analog_ctrl),
    .cnt_clk_in(cnt_clk_in), .gate_src(gate_src), .cmp_pin_oe(cmp_pin_oe),
    .int_request(int_request), .cmp_wake(cmp_wake)
);

// file: tb/cnt_partner.sv
// companion counter model: makes its (prescaled) clock, counts gated edges
// assumes the gate comes from the comparator block; clock parks high when stopped
`timescale 1ns/1ps
module cnt_partner (
    // control and gate
    input  wire logic  run,
    input  wire logic  gate,
    // counter side
    output logic        cnt_clk,
    output logic [15:0] count
);
    // toggles only on falling system clock edges, so no sampler ever races it
    initial begin
        cnt_clk = 1'b1;
        count = 16'h0000;
        forever begin
            #400;
            if (run || !cnt_clk) cnt_clk = !cnt_clk;
        end
    end
    // rising edge count, clear of the falling latch edge
    always @(posedge cnt_clk) if (gate) count <= count + 16'h0001;
endmodule

// file: tb/cmp_ctrl_bench.sv
// self-checking bench for the comparator control block with a register model
// assumes the register map of the shared header and the counter partner model
`timescale 1ns/1ps
module cmp_ctrl_bench;
    logic sys_clk, reset, reg_wr, reg_rd, cnt_clk_in, int_request, cmp_wake, run;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [1:0] raw_cmp_in, gate_src, cmp_pin_out, cmp_pin_oe;
    logic [15:0] count;
    cmp_ctrl_pkg::analog_ctrl_t analog_ctrl [2];
    int m [16];
    int o [2];
    int seed = 38468;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;

    cmp_ctrl #(.NUM_CMP(2)) u_cmp_ctrl (.sys_clk(sys_clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .raw_cmp_in(raw_cmp_in), .analog_ctrl(analog_ctrl),
        .cnt_clk_in(cnt_clk_in), .gate_src(gate_src), .cmp_pin_out(cmp_pin_out),
        .cmp_pin_oe(cmp_pin_oe), .int_request(int_request), .cmp_wake(cmp_wake));
    cnt_partner u_cnt_partner (.run(run), .gate(gate_src[0]), .cnt_clk(cnt_clk_in),
        .count(count));

    // ---
    // checking, bus and model tasks
    // ---
    task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task wr(input int a, input int d);
        @(posedge sys_clk);
        reg_addr <= a[3:0];
        reg_wdata <= d[7:0];
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        case (a)
            0, 2: m[a] = d & 8'hb7;
            1, 3: m[a] = d & 8'hf3;
            5: m[a] = d & 8'hc0;
            6, 7: m[a] = d & 8'h60;
            default: ;
        endcase
    endtask
    function automatic logic [7:0] exp_rd(input int a);
        case (a)
            0, 2: exp_rd = 8'(m[a] | (o[a/2] << 6));
            4: exp_rd = 8'(o[1] * 2 + o[0]);
            default: exp_rd = 8'(m[a]);
        endcase
    endfunction
    task rd(input int a);
        @(posedge sys_clk);
        reg_addr <= a[3:0];
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp_rd(a), "rdata");
    endtask
    // let the input pipe and any synced gate settle, then apply edges
    task settle;
        int n;
        int i;
        repeat (20) @(posedge sys_clk);
        for (i = 0; i < 2; i++) begin
            n = m[2*i][7] & raw_cmp_in[i] ^ m[2*i][4];
            if (n != o[i] && (n ? m[2*i+1][7] : m[2*i+1][6])) m[7] = m[7] | (32 << i);
            o[i] = n;
        end
    endtask
    task chk_out;
        int i;
        int irq;
        logic [7:0] hot;
        irq = 0;
        for (i = 0; i < 2; i++) begin
            check({7'h0, gate_src[i]}, 8'(o[i]), "gate");
            check({7'h0, cmp_pin_out[i]}, 8'(o[i]), "pin out");
            hot = m[2*i][7] ? 8'(1 << m[2*i+1][5:4]) : 8'h00;
            check({4'h0, analog_ctrl[i].plus_onehot}, hot, "plus");
            hot = m[2*i][7] ? 8'(1 << m[2*i+1][1:0]) : 8'h00;
            check({4'h0, analog_ctrl[i].minus_onehot}, hot, "minus");
            check({7'h0, cmp_pin_oe[i]}, 8'(m[2*i][5]), "oe");
            check({7'h0, analog_ctrl[i].cmp_on}, 8'(m[2*i][7]), "on");
            if (m[7][5+i] && m[6][5+i] && m[2*i][7] && m[2*i][2] && (m[2*i+1][7] || m[2*i+1][6]))
                irq = 1;
        end
        check({7'h0, cmp_wake}, 8'(irq), "wake");
        check({7'h0, int_request}, 8'(irq & m[5][7] & m[5][6]), "irq");
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict;
        end
    end

    initial begin
        int k, a, d;
        reset = 1'b1; reg_addr = 4'h0; reg_wdata = 8'h00; reg_wr = 1'b0;
        reg_rd = 1'b0; raw_cmp_in = 2'h0; run = 1'b0;
        foreach (m[j]) m[j] = 0;
        o = '{0, 0};
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        for (a = 0; a < 16; a++) rd(a);
        $display("reset values done");
        run <= 1'b1;
        for (k = 0; k < 150; k++) begin
            a = $random(seed) & 15;
            d = $random(seed);
            if (d[8]) begin
                @(posedge sys_clk);
                raw_cmp_in <= d[1:0];
            end else begin
                wr(a, d);
            end
            settle;
            chk_out;
            rd(a);
            rd(4);
            rd(7);
        end
        $display("random traffic done");
        // edge landing in the same cycle as the clearing write
        @(posedge sys_clk);
        raw_cmp_in <= 2'h0;
        wr(0, 8'h84);
        wr(1, 8'h80);
        settle;
        wr(7, 8'h00);
        raw_cmp_in[0] <= 1'b1;
        repeat (2) @(posedge sys_clk);
        wr(7, 8'h00);
        settle;
        rd(7);
        wr(7, 8'h00);
        settle;
        rd(7);
        // on/off and polarity toggles while disabled
        wr(1, 8'hc0);
        wr(0, 8'h00);
        settle;
        rd(7);
        wr(7, 8'h00);
        wr(0, 8'h10);
        settle;
        rd(7);
        $display("flag tests done");
        // synced gate holds while the counter clock is parked
        @(posedge sys_clk);
        raw_cmp_in <= 2'h0;
        wr(0, 8'h81);
        settle;
        run <= 1'b0;
        repeat (10) @(posedge sys_clk);
        raw_cmp_in[0] <= 1'b1;
        repeat (20) @(posedge sys_clk);
        check({7'h0, gate_src[0]}, 8'h00, "parked gate");
        run <= 1'b1;
        settle;
        chk_out;
        check({7'h0, |count}, 8'h01, "count");
        $display("sync test done");
        give_verdict;
    end
endmodule
